// file: design/fcs_pkg.sv
// Shared constants and types for the flash command sequencer link.
// Assumes both ends run on one 100 MHz clock and meet in fcs_link_if.
package fcs_pkg;

  // Command address byte lives in addr[15:8]
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_ADDR_MSB = 15;
  localparam logic [7:0] CMD_ADDR_A = 8'h54;
  localparam logic [7:0] CMD_ADDR_B = 8'haa;

  // Command data bytes, only the low byte of a written word is decoded
  localparam logic [7:0] UNLOCK_1    = 8'haa;
  localparam logic [7:0] UNLOCK_2    = 8'h55;
  localparam logic [7:0] CMD_READ    = 8'hf0;
  localparam logic [7:0] CMD_ID      = 8'h90;
  localparam logic [7:0] CMD_PROG    = 8'ha0;
  localparam logic [7:0] CMD_ERASE   = 8'h80;
  localparam logic [7:0] CMD_CHIP    = 8'h10;
  localparam logic [7:0] CMD_BLOCK   = 8'h30;
  localparam logic [7:0] CMD_PBPROG  = 8'h9a;
  localparam logic [7:0] CMD_PBERASE = 8'h6a;
  localparam logic [7:0] ID_SUB      = 8'h00;

  // Device register window: addr[31:16] selects it, addr[15:0] the register
  localparam logic [15:0] REG_BASE     = 16'h4000;
  localparam logic [15:0] STATUS_OFS   = 16'h0000;
  localparam logic [15:0] SECURITY_OFS = 16'h0004;
  localparam logic [31:0] STATUS_ADDR  = {REG_BASE, STATUS_OFS};
  localparam int RDY_BIT   = 0;
  localparam int GUARD_LSB = 16;
  localparam int GUARD_MAX = 6;
  localparam int SEC_BIT   = 0;
  localparam logic SEC_RST = 1'b1;
  localparam logic RDY_RST = 1'b1;

  // Timing
  localparam int CLK_NS       = 10;
  localparam int RST_HOLD_NS  = 500;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BOOT_US      = 2000;
  localparam int BOOT_CYC     = BOOT_US * 1000 / CLK_NS;

  // Controller register offsets
  localparam logic [7:0] H_CMD    = 8'h00;
  localparam logic [7:0] H_ADDR   = 8'h04;
  localparam logic [7:0] H_DATA0  = 8'h08;
  localparam logic [7:0] H_DATA1  = 8'h0c;
  localparam logic [7:0] H_DATA2  = 8'h10;
  localparam logic [7:0] H_DATA3  = 8'h14;
  localparam logic [7:0] H_RESULT = 8'h18;
  localparam logic [7:0] H_STAT   = 8'h1c;
  localparam logic [7:0] H_IRQ    = 8'h20;
  localparam logic [7:0] H_MASK   = 8'h24;
  localparam logic [7:0] H_RECOV  = 8'h28;
  localparam int EV_DONE   = 0;
  localparam int EV_REFUSE = 1;

  typedef enum logic [2:0] {
    OP_READ, OP_ID, OP_PROG, OP_CHIP, OP_BLOCK, OP_PBPROG, OP_PBERASE
  } fcs_op_e;

  typedef struct packed {
    logic        rd;
    logic [31:0] addr;
    logic [31:0] data;
  } fcs_step_s;

endpackage : fcs_pkg

// file: design/fcs_link_if.sv
// Word bus between the controller and the flash command decoder.
// Assumes one clock; read data stand only in the cycle after rd.
`timescale 1ns/100ps
interface fcs_link_if;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  logic        rstReq_n;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    output rstReq_n,
    input  rdata
  );
endinterface : fcs_link_if

// file: design/fcs_flash_device.sv
// Flash command sequence decoder with a small word array, guard flags,
// status and security registers.
// Assumes the bench merges link.rstReq_n into arst_n; coldRst_n is power-on.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps

// Overview of operation
// [RL1] Host starts sequences only when ready
// [RL2] Recovery reset held at least 0.5 us
// [RL3] Array reads valid about 2 ms after reset
// [RL4] Security bit 0, cold reset to one
// [RL5] Missing guard bits read zero
// [RL6] All cycles write except three read cycles
// [RL7] Word writes, low byte decoded
// [RL8] Host keeps address bits 1:0 zero
// [RL9] Unlock prefix AA@54, 55@AA, command@54
// [RL10] Command address sits in addr 15:8
// [RL11] Read/Reset: fourth cycle reads array
// [RL12] ID read: write 00, then read identifier
// [RL13] Program four ascending words per page
// [RL14] Erase: 80, second unlock, 10 or 30
// [RL15] Guard flag program 9A, erase 6A
// [RL16] Recommended-zero address bits are ignored
// [RL17] Ready low while busy, stuck on failure
// [RL18] Guarded block rejects program and erase
// [RL19] Unexpected cycle drops back to read mode
module fcs_flash_device #(
  parameter int          NBLK      = 6,
  parameter int          BLK_SHIFT = 3,
  parameter int          OP_CYC    = 64,
  parameter int          BOOT_CYC  = fcs_pkg::BOOT_CYC,
  parameter logic [31:0] MAKER_ID  = 32'h0000_005a,  // Arbitrary value
  parameter logic [31:0] PART_ID   = 32'h0000_00c3   // Arbitrary value
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic coldRst_n,
  fcs_link_if.dev   link,
  output logic      lockEnable,
  output logic      autoOpDone,
  output logic      arrayValid
);

  localparam int DEPTH = NBLK << BLK_SHIFT;
  localparam int AW    = $clog2(DEPTH);
  localparam int BW    = (NBLK > 1) ? $clog2(NBLK) : 1;

  // The guard field has only six status positions
  if (NBLK < 1 || NBLK > fcs_pkg::GUARD_MAX || BLK_SHIFT < 2) begin : g_bad_cfg
    $error("fcs_flash_device: NBLK must be 1..6 and BLK_SHIFT at least 2");
  end
  if (OP_CYC < 1 || BOOT_CYC < 1) begin : g_bad_time
    $error("fcs_flash_device: OP_CYC and BOOT_CYC must be positive");
  end

  typedef enum {
    S_IDLE, S_U1, S_U2, S_RR, S_IDW, S_IDR, S_PG, S_E1, S_E2, S_E3, S_P7
  } fcs_dst_e;

  typedef struct packed {
    fcs_dst_e                 st;
    logic [7:0]               code;
    logic [1:0]               cnt;
    logic [AW-1:0]            page;
    logic [2:0][31:0]         pbuf;
    logic [NBLK-1:0]          guard;
    logic                     failed;
    logic                     booted;
    logic [31:0]              bootCnt;
    logic [15:0]              opCnt;
    logic                     ready;
    logic                     idSel;
    logic [31:0]              rdata;
    logic [DEPTH-1:0][31:0]   mem;
  } fcs_dstate_s;

  fcs_dstate_s q_ff;
  fcs_dstate_s nxt_q;
  logic        secEn_ff;

  logic [AW-1:0] idx;
  logic          inArr;
  logic          isReg;
  logic [7:0]    ca;
  logic [7:0]    cd;
  logic [BW-1:0] blk;
  logic [BW-1:0] pblk;
  logic          wrOk;
  logic [31:0]   statusWord;

  // Address fields; bits outside these slices are looked at only by the array range check, the register window decode and the register offset compares
  assign idx   = link.addr[AW+1:2];                                   // RL16
  assign inArr = (link.addr[31:AW+2] == '0) && (int'(idx) < DEPTH);
  assign isReg = link.addr[31:16] == fcs_pkg::REG_BASE;
  assign ca    = link.addr[fcs_pkg::CMD_ADDR_MSB:fcs_pkg::CMD_ADDR_LSB];
  assign cd    = link.wdata[7:0];                                     // RL7
  assign blk   = BW'(idx >> BLK_SHIFT);
  assign pblk  = BW'(q_ff.page >> BLK_SHIFT);

  // Writes while busy, failed or booting are dropped, as the host was warned
  assign wrOk = link.wr && !isReg && q_ff.ready && q_ff.booted;        // RL1

  // Guard field is NBLK wide; unused upper positions stay zero
  always_comb begin
    statusWord = '0;
    statusWord[fcs_pkg::RDY_BIT] = q_ff.ready;                          // RL17
    statusWord[fcs_pkg::GUARD_LSB +: NBLK] = q_ff.guard;                // RL5
  end

  // Next-state logic for decoder, array and status
  always_comb begin
    nxt_q = q_ff;
    nxt_q.rdata = '0;
    if (q_ff.opCnt != '0) begin
      nxt_q.opCnt = q_ff.opCnt - 16'h0001;
    end
    if (q_ff.bootCnt != '0) begin
      nxt_q.bootCnt = q_ff.bootCnt - 32'h0000_0001;
    end else begin
      nxt_q.booted = 1'b1;                                               // RL3
    end

    // Reads: register window, identifier, or plain array data
    if (link.rd) begin
      if (isReg) begin
        case (link.addr[15:0])
          fcs_pkg::STATUS_OFS:   nxt_q.rdata = statusWord;
          fcs_pkg::SECURITY_OFS: nxt_q.rdata = {31'h0, secEn_ff};        // RL4
          default:               nxt_q.rdata = '0;
        endcase
      end else if (q_ff.st == S_IDR) begin
        nxt_q.rdata = q_ff.idSel ? PART_ID : MAKER_ID;                   // RL12
        nxt_q.st    = S_IDLE;
      end else begin
        if (q_ff.booted && inArr) begin
          nxt_q.rdata = q_ff.mem[idx];                                   // RL11
        end
        nxt_q.st = S_IDLE;                                               // RL6
      end
    end

    // Writes walk the command sequence; any mismatch falls back to idle
    if (wrOk) begin
      nxt_q.st = S_IDLE;                                                 // RL19
      case (q_ff.st)
        S_IDLE: begin
          if (ca == fcs_pkg::CMD_ADDR_A && cd == fcs_pkg::UNLOCK_1) begin // RL9
            nxt_q.st = S_U1;
          end
        end
        S_U1: begin
          if (ca == fcs_pkg::CMD_ADDR_B && cd == fcs_pkg::UNLOCK_2) begin // RL9
            nxt_q.st = S_U2;
          end
        end
        S_U2: begin
          nxt_q.code = cd;
          nxt_q.cnt  = 2'h0;
          if (ca == fcs_pkg::CMD_ADDR_A) begin
            case (cd)
              fcs_pkg::CMD_READ:    nxt_q.st = S_RR;                     // RL11
              fcs_pkg::CMD_ID:      nxt_q.st = S_IDW;                    // RL12
              fcs_pkg::CMD_PROG:    nxt_q.st = S_PG;                     // RL13
              fcs_pkg::CMD_ERASE:   nxt_q.st = S_E1;                     // RL14
              fcs_pkg::CMD_PBPROG:  nxt_q.st = S_E1;                     // RL15
              fcs_pkg::CMD_PBERASE: nxt_q.st = S_E1;                     // RL15
              default:              nxt_q.st = S_IDLE;
            endcase
          end
        end
        S_IDW: begin
          if (cd == fcs_pkg::ID_SUB) begin                               // RL12
            nxt_q.idSel = idx[0];
            nxt_q.st    = S_IDR;
          end
        end
        S_PG: begin
          // Words must arrive in ascending order inside one page
          if (inArr && idx[1:0] == q_ff.cnt &&
              (q_ff.cnt == 2'h0 || idx[AW-1:2] == q_ff.page[AW-1:2])) begin // RL13
            nxt_q.cnt = q_ff.cnt + 2'h1;
            nxt_q.st  = S_PG;
            if (q_ff.cnt == 2'h0) begin
              nxt_q.page = idx;
            end
            if (q_ff.cnt != 2'h3) begin
              nxt_q.pbuf[q_ff.cnt] = link.wdata;
            end else begin
              nxt_q.st    = S_IDLE;
              nxt_q.opCnt = 16'(OP_CYC);
              if (q_ff.guard[pblk]) begin
                nxt_q.failed = 1'b1;                                     // RL18
              end else begin
                for (int i = 0; i < 3; i++) begin
                  nxt_q.mem[{q_ff.page[AW-1:2], 2'(i)}] = q_ff.pbuf[i];
                end
                nxt_q.mem[{q_ff.page[AW-1:2], 2'h3}] = link.wdata;
              end
            end
          end
        end
        S_E1: begin
          if (ca == fcs_pkg::CMD_ADDR_A && cd == fcs_pkg::UNLOCK_1) begin // RL14
            nxt_q.st = S_E2;
          end
        end
        S_E2: begin
          if (ca == fcs_pkg::CMD_ADDR_B && cd == fcs_pkg::UNLOCK_2) begin // RL14
            nxt_q.st = S_E3;
          end
        end
        S_E3: begin
          if (q_ff.code == fcs_pkg::CMD_ERASE) begin
            if (ca == fcs_pkg::CMD_ADDR_A && cd == fcs_pkg::CMD_CHIP) begin // RL14
              // Guarded blocks survive a chip erase and flag the failure
              nxt_q.opCnt = 16'(OP_CYC);
              nxt_q.failed = |q_ff.guard;                                // RL18
              for (int i = 0; i < DEPTH; i++) begin
                if (!q_ff.guard[i >> BLK_SHIFT]) begin
                  nxt_q.mem[i] = '1;
                end
              end
            end else if (inArr && cd == fcs_pkg::CMD_BLOCK) begin         // RL14
              nxt_q.opCnt = 16'(OP_CYC);
              if (q_ff.guard[blk]) begin
                nxt_q.failed = 1'b1;                                     // RL18
              end else begin
                for (int i = 0; i < DEPTH; i++) begin
                  if ((i >> BLK_SHIFT) == int'(blk)) begin
                    nxt_q.mem[i] = '1;
                  end
                end
              end
            end
          end else if (ca == fcs_pkg::CMD_ADDR_A && cd == q_ff.code) begin // RL15
            nxt_q.st = S_P7;
          end
        end
        S_P7: begin
          if (cd == q_ff.code && inArr) begin                            // RL15
            nxt_q.opCnt = 16'(OP_CYC);
            if (q_ff.code == fcs_pkg::CMD_PBPROG) begin
              nxt_q.guard[blk] = 1'b1;
            end else begin
              nxt_q.guard = '0;
            end
          end
        end
        default: nxt_q.st = S_IDLE;
      endcase
    end

    // Ready drops with the operation and stays low after a failure
    nxt_q.ready = (nxt_q.opCnt == '0) && !nxt_q.failed;                  // RL17
  end

  // State register; array resets to the erased value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff         <= '0;
      q_ff.st      <= S_IDLE;
      q_ff.mem     <= '1;
      q_ff.ready   <= fcs_pkg::RDY_RST;                                  // RL17
      q_ff.bootCnt <= 32'(BOOT_CYC);                                     // RL3
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Security bit survives system reset, only power-on resets it
  always_ff @(posedge mclk or negedge coldRst_n) begin
    if (!coldRst_n) begin
      secEn_ff <= fcs_pkg::SEC_RST;                                      // RL4
    end else if (link.wr && isReg && link.addr[15:0] == fcs_pkg::SECURITY_OFS) begin
      secEn_ff <= link.wdata[fcs_pkg::SEC_BIT];                          // RL4
    end
  end

  assign link.rdata = q_ff.rdata;
  assign lockEnable = secEn_ff;
  assign autoOpDone = q_ff.ready;
  assign arrayValid = q_ff.booted;

endmodule : fcs_flash_device

// file: design/fcs_flash_ctrl.sv
// Controller that turns register commands into flash bus sequences.
// Assumes a software port with read data one cycle after the strobe.
`timescale 1ns/100ps
module fcs_flash_ctrl (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  fcs_link_if.host         link,
  input  wire logic [7:0]  swAddr,
  input  wire logic [31:0] swWdata,
  input  wire logic        swWe,
  input  wire logic        swRe,
  output logic [31:0]      swRdata,
  output logic             irq
);

  typedef enum {H_IDLE, H_PRE, H_PREC, H_SEQ, H_CAP, H_POST, H_POSTC, H_RST} fcs_hst_e;

  typedef struct packed {
    fcs_hst_e         st;
    fcs_pkg::fcs_op_e op;
    logic [2:0]       n;
    logic [31:0]      base;
    logic [3:0][31:0] dat;
    logic [31:0]      result;
    logic [1:0]       irqSt;
    logic [1:0]       irqMask;
    logic             irq;
    logic             rdPend;
    logic [31:0]      bAddr;
    logic [31:0]      bWdata;
    logic             bWr;
    logic             bRd;
    logic [31:0]      swRdata;
    logic             rstN;
    logic [7:0]       rstCnt;
  } fcs_hstate_s;

  fcs_hstate_s q_ff;
  fcs_hstate_s nxt_q;
  fcs_pkg::fcs_step_s step;
  logic [1:0]  ev;
  logic [1:0]  clr;

  // Command word at addr[15:8], all other bits zero with [1:0] fixed
  function automatic logic [31:0] cmdAddr(input logic [7:0] c);
    cmdAddr = {16'h0, c, 8'h00};
  endfunction : cmdAddr

  function automatic logic [2:0] lastOf(input fcs_pkg::fcs_op_e op);
    case (op)
      fcs_pkg::OP_READ:  lastOf = 3'h3;
      fcs_pkg::OP_ID:    lastOf = 3'h4;
      fcs_pkg::OP_CHIP:  lastOf = 3'h5;
      fcs_pkg::OP_BLOCK: lastOf = 3'h5;
      default:           lastOf = 3'h6;
    endcase
  endfunction : lastOf

  // One bus cycle of a sequence; reads only where a read is due
  function automatic fcs_pkg::fcs_step_s stepOf(input fcs_pkg::fcs_op_e op,
      input logic [2:0] n, input logic [31:0] base, input logic [3:0][31:0] dat);
    fcs_pkg::fcs_step_s s;
    logic [7:0]  code;
    logic [31:0] pg;
    logic [31:0] a54;
    logic [31:0] aAA;
    s    = '0;
    pg   = {base[31:4], 4'h0};
    a54  = cmdAddr(fcs_pkg::CMD_ADDR_A);
    aAA  = cmdAddr(fcs_pkg::CMD_ADDR_B);
    case (op)
      fcs_pkg::OP_READ:   code = fcs_pkg::CMD_READ;
      fcs_pkg::OP_ID:     code = fcs_pkg::CMD_ID;
      fcs_pkg::OP_PROG:   code = fcs_pkg::CMD_PROG;
      fcs_pkg::OP_PBPROG: code = fcs_pkg::CMD_PBPROG;
      fcs_pkg::OP_PBERASE: code = fcs_pkg::CMD_PBERASE;
      default:            code = fcs_pkg::CMD_ERASE;
    endcase
    case (n)
      3'h0: s = '{1'b0, a54, {24'h0, fcs_pkg::UNLOCK_1}};
      3'h1: s = '{1'b0, aAA, {24'h0, fcs_pkg::UNLOCK_2}};
      3'h2: s = '{1'b0, a54, {24'h0, code}};
      3'h3: begin
        case (op)
          fcs_pkg::OP_READ: s = '{1'b1, {base[31:2], 2'h0}, 32'h0};
          fcs_pkg::OP_ID:   s = '{1'b0, {base[31:2], 2'h0}, {24'h0, fcs_pkg::ID_SUB}};
          fcs_pkg::OP_PROG: s = '{1'b0, pg, dat[0]};
          default:          s = '{1'b0, a54, {24'h0, fcs_pkg::UNLOCK_1}};
        endcase
      end
      3'h4: begin
        case (op)
          fcs_pkg::OP_ID:   s = '{1'b1, {base[31:2], 2'h0}, 32'h0};
          fcs_pkg::OP_PROG: s = '{1'b0, pg + 32'h4, dat[1]};
          default:          s = '{1'b0, aAA, {24'h0, fcs_pkg::UNLOCK_2}};
        endcase
      end
      3'h5: begin
        case (op)
          fcs_pkg::OP_PROG:  s = '{1'b0, pg + 32'h8, dat[2]};
          fcs_pkg::OP_CHIP:  s = '{1'b0, a54, {24'h0, fcs_pkg::CMD_CHIP}};
          fcs_pkg::OP_BLOCK: s = '{1'b0, {base[31:2], 2'h0}, {24'h0, fcs_pkg::CMD_BLOCK}};
          default:           s = '{1'b0, a54, {24'h0, code}};
        endcase
      end
      default: begin
        if (op == fcs_pkg::OP_PROG) begin
          s = '{1'b0, pg + 32'hc, dat[3]};
        end else begin
          s = '{1'b0, {base[31:2], 2'h0}, {24'h0, code}};
        end
      end
    endcase
    return s;
  endfunction : stepOf

  assign step = stepOf(q_ff.op, q_ff.n, q_ff.base, q_ff.dat);             // RL8
  assign clr  = (swWe && swAddr == fcs_pkg::H_IRQ) ? swWdata[1:0] : 2'h0;

  // Software port, sequencing and interrupt status
  always_comb begin
    nxt_q        = q_ff;
    ev           = 2'h0;
    nxt_q.bWr    = 1'b0;
    nxt_q.bRd    = 1'b0;
    nxt_q.bAddr  = '0;
    nxt_q.bWdata = '0;
    nxt_q.swRdata = '0;
    nxt_q.rdPend = q_ff.bRd;

    // Register writes; a start while busy or with a bad code is refused
    if (swWe) begin
      case (swAddr)
        fcs_pkg::H_CMD: begin
          if (q_ff.st == H_IDLE && swWdata[2:0] <= 3'(fcs_pkg::OP_PBERASE)) begin
            nxt_q.op = fcs_pkg::fcs_op_e'(swWdata[2:0]);
            nxt_q.n  = 3'h0;
            nxt_q.st = H_PRE;
          end else begin
            ev[fcs_pkg::EV_REFUSE] = 1'b1;
          end
        end
        fcs_pkg::H_ADDR:  nxt_q.base = swWdata;
        fcs_pkg::H_DATA0: nxt_q.dat[0] = swWdata;
        fcs_pkg::H_DATA1: nxt_q.dat[1] = swWdata;
        fcs_pkg::H_DATA2: nxt_q.dat[2] = swWdata;
        fcs_pkg::H_DATA3: nxt_q.dat[3] = swWdata;
        fcs_pkg::H_MASK:  nxt_q.irqMask = swWdata[1:0];
        fcs_pkg::H_RECOV: begin
          nxt_q.st     = H_RST;
          nxt_q.rstN   = 1'b0;
          nxt_q.rstCnt = 8'(fcs_pkg::RST_HOLD_CYC);                      // RL2
        end
        default: ;
      endcase
    end

    if (swRe) begin
      case (swAddr)
        fcs_pkg::H_ADDR:   nxt_q.swRdata = q_ff.base;
        fcs_pkg::H_RESULT: nxt_q.swRdata = q_ff.result;
        fcs_pkg::H_STAT:   nxt_q.swRdata = {30'h0, q_ff.st == H_RST, q_ff.st != H_IDLE};
        fcs_pkg::H_IRQ:    nxt_q.swRdata = {30'h0, q_ff.irqSt};
        fcs_pkg::H_MASK:   nxt_q.swRdata = {30'h0, q_ff.irqMask};
        default:           nxt_q.swRdata = '0;
      endcase
    end

    case (q_ff.st)
      H_IDLE: ;
      // Poll ready before the first cycle of a sequence
      H_PRE: begin
        nxt_q.bRd   = 1'b1;
        nxt_q.bAddr = fcs_pkg::STATUS_ADDR;
        nxt_q.st    = H_PREC;
      end
      H_PREC: begin
        if (q_ff.rdPend) begin
          nxt_q.st = link.rdata[fcs_pkg::RDY_BIT] ? H_SEQ : H_PRE;       // RL1
        end
      end
      H_SEQ: begin
        nxt_q.bWr    = !step.rd;                                         // RL6
        nxt_q.bRd    = step.rd;
        nxt_q.bAddr  = step.addr;                                        // RL10
        nxt_q.bWdata = step.data;                                        // RL7
        if (q_ff.n == lastOf(q_ff.op)) begin
          nxt_q.st = step.rd ? H_CAP : H_POST;
        end else begin
          nxt_q.n = q_ff.n + 3'h1;
        end
      end
      H_CAP: begin
        if (q_ff.rdPend) begin
          nxt_q.result = link.rdata;
          ev[fcs_pkg::EV_DONE] = 1'b1;
          nxt_q.st = H_IDLE;
        end
      end
      // Wait out the automatic operation; a failed one never completes
      H_POST: begin
        nxt_q.bRd   = 1'b1;
        nxt_q.bAddr = fcs_pkg::STATUS_ADDR;
        nxt_q.st    = H_POSTC;
      end
      H_POSTC: begin
        if (q_ff.rdPend) begin
          if (link.rdata[fcs_pkg::RDY_BIT]) begin
            ev[fcs_pkg::EV_DONE] = 1'b1;
            nxt_q.st = H_IDLE;
          end else begin
            nxt_q.st = H_POST;
          end
        end
      end
      H_RST: begin
        nxt_q.rstCnt = q_ff.rstCnt - 8'h01;
        if (q_ff.rstCnt == 8'h01) begin
          nxt_q.rstN = 1'b1;                                             // RL2
          nxt_q.st   = H_IDLE;
        end
      end
      default: nxt_q.st = H_IDLE;
    endcase

    // Recovery wins over any sequence step; a stuck poll loop must not eat it
    if (swWe && swAddr == fcs_pkg::H_RECOV) begin
      nxt_q.st = H_RST;                                                  // RL2
    end

    // Set wins over a write-one clear in the same cycle
    nxt_q.irqSt = (q_ff.irqSt & ~clr) | ev;
    nxt_q.irq   = |(nxt_q.irqSt & nxt_q.irqMask);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff      <= '0;
      q_ff.st   <= H_IDLE;
      q_ff.rstN <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign link.addr     = q_ff.bAddr;
  assign link.wdata    = q_ff.bWdata;
  assign link.wr       = q_ff.bWr;
  assign link.rd       = q_ff.bRd;
  assign link.rstReq_n = q_ff.rstN;
  assign swRdata       = q_ff.swRdata;
  assign irq           = q_ff.irq;

endmodule : fcs_flash_ctrl

// file: tb/fcs_link_monitor.sv
// Checker for the word bus between the flash controller and decoder.
// Assumes one clock; arst_n is the controller reset.
`timescale 1ns/100ps
module fcs_link_monitor (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        rstReq_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Strobes, alignment and idle read data
  AST_ONE_STROBE: assert property (!(wr && rd))
    else $error("strobe clash");
  AST_ADDR_LOW: assert property ((wr || rd) |-> addr[1:0] == 2'h0)
    else $error("address low bits set");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata outside slot");
  // Four blocks only, so guard bits 21:20 stay zero
  AST_STATUS_ZERO: assert property (
    rd && addr == fcs_pkg::STATUS_ADDR |=> rdata[31:20] == 12'h0)
    else $error("status upper bits set");
  // Prefix runs back to back, one word a cycle
  AST_UNLOCK: assert property (
    wr && wdata[7:0] == 8'haa && addr[15:8] == 8'h54 |=>
    (wr && wdata[7:0] == 8'h55 && addr[15:8] == 8'haa) ##1
    (wr && (addr[15:8] == 8'h54 || wdata[7:0] == 8'h30))) // Block erase ends at its block
    else $error("unlock prefix broken");
  AST_PROG_WORDS: assert property (
    wr && wdata[7:0] == 8'ha0 && addr[15:8] == 8'h54 |=> (wr && addr[3:2] == 2'h0)
    ##1 (wr && addr[3:2] == 2'h1) ##1 (wr && addr[3:2] == 2'h2) ##1 (wr && addr[3:2] == 2'h3))
    else $error("page words out of order");
  AST_ERASE_TAIL: assert property (
    wr && wdata[7:0] == 8'h80 |-> ##3 wr && (wdata[7:0] == 8'h10 || wdata[7:0] == 8'h30))
    else $error("erase tail wrong");
  // Recovery reset must last 0.5 us at 100 MHz
  AST_RECOV: assert property ($fell(rstReq_n) |-> ##49 !rstReq_n ##1 rstReq_n)
    else $error("recovery pulse length");
endmodule : fcs_link_monitor

// file: tb/flash_command_sequencer_tb.sv
// Bench: controller and flash decoder joined by the link, driven by software port.
// Assumes short boot and operation counts set below.
`timescale 1ns/100ps
module flash_command_sequencer_tb;
  logic        mclk, arst_n, coldRst_n, swWe, swRe, irq, lockEnable, autoOpDone, arrayValid;
  logic [7:0]  swAddr;
  logic [31:0] swWdata, swRdata, v;
  int          failures, comparisons;
  fcs_link_if link ();
  wire         devRst_n = arst_n & link.rstReq_n;
  // Identifier values are arbitrary
  fcs_flash_device #(.NBLK(4), .OP_CYC(4), .BOOT_CYC(20), .MAKER_ID(32'h5a), .PART_ID(32'hc3))
    i_fcs_flash_device (.mclk(mclk),
    .arst_n(devRst_n), .coldRst_n(coldRst_n), .link(link), .lockEnable(lockEnable),
    .autoOpDone(autoOpDone), .arrayValid(arrayValid));
  fcs_flash_ctrl i_fcs_flash_ctrl (.mclk(mclk), .arst_n(arst_n), .link(link), .swAddr(swAddr),
    .swWdata(swWdata), .swWe(swWe), .swRe(swRe), .swRdata(swRdata), .irq(irq));
  fcs_link_monitor i_fcs_link_monitor (.mclk(mclk), .arst_n(arst_n), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .wr(link.wr), .rd(link.rd), .rstReq_n(link.rstReq_n));
  // Software port: one-cycle strobes, read data in the next cycle
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    swAddr <= a;
    swWdata <= d;
    swWe <= 1'b1;
    @(posedge mclk);
    swWe <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    swAddr <= a;
    swRe <= 1'b1;
    @(posedge mclk);
    swRe <= 1'b0;
    #1 d = swRdata;
  endtask : rd
  // Start a command, poll for done under a bound, then clear the event
  task op(input logic [2:0] c, input logic [31:0] a, input logic e);
    wr(fcs_pkg::H_ADDR, a);
    wr(fcs_pkg::H_CMD, {29'h0, c});
    v = 32'h0;
    repeat (40) if (!v[0]) rd(fcs_pkg::H_IRQ, v);
    chk("done", {31'h0, e}, {31'h0, v[0]});
    chk("irq", {31'h0, e}, {31'h0, irq});
    wr(fcs_pkg::H_IRQ, 32'h1);
  endtask : op
  task rdarr(input logic [31:0] a, input logic [31:0] e);
    op(3'h0, a, 1'b1);
    rd(fcs_pkg::H_RESULT, v);
    chk("array", e, v);
  endtask : rdarr
  task complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cuts a hang well past the expected run length
  initial begin
    #60000;
    failures++;
    complete_run();
  end
  initial begin
    {arst_n, coldRst_n, swWe, swRe, swAddr, swWdata} = '0;
    failures = 0;
    comparisons = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    coldRst_n <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("lockEnable", 32'h1, {31'h0, lockEnable});
    wr(fcs_pkg::H_MASK, 32'h1);
    for (int i = 0; i < 4; i++) wr(fcs_pkg::H_DATA0 + 8'(4 * i), 32'h1000 + i);
    op(3'h2, 32'h20, 1'b1);
    for (int i = 0; i < 4; i++) rdarr(32'h20 + 4 * i, 32'h1000 + i);
    op(3'h1, 32'h0, 1'b1);
    rd(fcs_pkg::H_RESULT, v);
    chk("maker id", 32'h5a, v);
    op(3'h1, 32'h4, 1'b1);
    rd(fcs_pkg::H_RESULT, v);
    chk("part id", 32'hc3, v);
    op(3'h4, 32'h2c, 1'b1);
    rdarr(32'h24, 32'hffffffff);
    op(3'h5, 32'h20, 1'b1);
    op(3'h2, 32'h20, 1'b0);
    chk("autoOpDone", 32'h0, {31'h0, autoOpDone});
    wr(fcs_pkg::H_MASK, 32'h0);
    wr(fcs_pkg::H_CMD, 32'h0);
    rd(fcs_pkg::H_IRQ, v);
    chk("refused", 32'h2, v & 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(fcs_pkg::H_RECOV, 32'h1);
    repeat (60) @(posedge mclk);
    #1 chk("arrayValid", 32'h0, {31'h0, arrayValid});
    repeat (40) @(posedge mclk);
    #1 chk("arrayValid", 32'h1, {31'h0, arrayValid});
    chk("autoOpDone", 32'h1, {31'h0, autoOpDone});
    wr(fcs_pkg::H_IRQ, 32'h3);
    wr(fcs_pkg::H_MASK, 32'h1);
    rdarr(32'h20, 32'hffffffff);
    op(3'h5, 32'h20, 1'b1);
    op(3'h6, 32'h20, 1'b1);
    op(3'h2, 32'h20, 1'b1);
    rdarr(32'h2c, 32'h1003);
    op(3'h3, 32'h0, 1'b1);
    rdarr(32'h2c, 32'hffffffff);
    complete_run();
  end
endmodule : flash_command_sequencer_tb
